/* devctl_pkg.sv */
package devctl_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// printed register offsets are indices; byte address is four times
	localparam logic [ADDR_W-1:0] IDX_DEVICE_CONTROL = 12'h048;
	localparam logic [ADDR_W-1:0] IDX_DEVICE_STATUS = 12'h04a;
	localparam logic [ADDR_W-1:0] ADDR_DEVICE_CONTROL =
		{IDX_DEVICE_CONTROL[ADDR_W-3:0], 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DEVICE_STATUS =
		{IDX_DEVICE_STATUS[ADDR_W-3:0], 2'h0};
	// transaction layer debug control and interrupt mask
	localparam logic [ADDR_W-1:0] ADDR_TL_CONTROL = 12'h140;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h144;

	// device_control field positions
	localparam int CTL_REPORT_LSB = 0;
	localparam int CTL_RELAXED_ORDER = 4;
	localparam int CTL_PAYLOAD_LSB = 5;
	localparam int CTL_WIDE_TAG = 8;
	localparam int CTL_PHANTOM = 9;
	localparam int CTL_AUX_POWER = 10;
	localparam int CTL_NO_SNOOP = 11;
	localparam int CTL_READ_SIZE_LSB = 12;
	// bits that software may change
	localparam logic [REG_W-1:0] CTL_WRITABLE = 16'h05ef;
	localparam logic [REG_W-1:0] CTL_RESET = 16'h0000;

	// device_status field positions
	localparam int STS_ERR_LSB = 0;
	localparam int STS_AUX_PRESENT = 4;
	localparam int STS_OUTSTANDING = 5;
	localparam int NUM_ERR = 4;
	localparam logic [NUM_ERR-1:0] STS_RESET = 4'h0;

	// tl control: sequential tag debug enable
	localparam int TLC_SEQ_TAG = 0;

	// payload size codes; every other code behaves as 128 bytes
	localparam logic [2:0] PAYLOAD_128 = 3'h0;
	localparam logic [2:0] PAYLOAD_256 = 3'h1;

	// generated tag ranges
	localparam logic [7:0] TAG_MAX_NARROW = 8'h1f;
	localparam logic [7:0] TAG_MAX_WIDE = 8'hff;
	localparam logic [7:0] TAG_RESET = 8'h00;

	// error events, bit order matches status bits 3..0
	typedef struct packed {
		logic unsupported;
		logic fatal;
		logic nonfatal;
		logic correctable;
	} err_evt_t;

	// control state handed to the port core
	typedef struct packed {
		logic unsupported_req_report_en;
		logic fatal_report_en;
		logic nonfatal_report_en;
		logic correctable_report_en;
		logic payload_256;
		logic wide_tag_en;
		logic aux_power_en;
		logic sequential_tag_debug;
	} ctl_out_t;

endpackage : devctl_pkg

/* express_device_ctl_status.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module express_device_ctl_status (
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic aux_rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [devctl_pkg::ADDR_W-1:0] paddr,
	input wire logic [devctl_pkg::DATA_W-1:0] pwdata,
	output logic [devctl_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// port core events and levels
	input wire devctl_pkg::err_evt_t err_evt,
	input wire logic unsup_req_rcvd,
	input wire logic aux_power_detect,
	input wire logic tag_advance,
	// control to the port core
	output devctl_pkg::ctl_out_t ctl,
	output logic [7:0] gen_tag,
	// interrupt
	output logic irq
);

	// software-visible state
	logic [3:0] report_en_r; // error reporting enables
	logic [2:0] payload_r; // raw payload size code
	logic wide_tag_r; // extended tag enable
	logic aux_en_r; // aux power enable, aux well
	logic seq_tag_r; // sequential tag debug
	logic [devctl_pkg::NUM_ERR-1:0] err_seen_r; // sticky flags
	logic [devctl_pkg::NUM_ERR-1:0] irq_mask_r; // interrupt mask
	logic aux_present_r; // aux power seen
	logic [7:0] tag_r; // debug tag counter

	// decoded access
	logic wr_en; // write completes this edge
	logic setup; // setup phase of a transfer
	logic hit_ctl, hit_sts, hit_tlc, hit_mask, hit_any;
	logic [devctl_pkg::REG_W-1:0] ctl_word, sts_word;
	logic [devctl_pkg::NUM_ERR-1:0] err_in;
	logic [devctl_pkg::NUM_ERR-1:0] w1c;
	logic [devctl_pkg::DATA_W-1:0] rd_nxt;
	logic [7:0] tag_max;

	// address decode
	assign hit_ctl = paddr == devctl_pkg::ADDR_DEVICE_CONTROL;
	assign hit_sts = paddr == devctl_pkg::ADDR_DEVICE_STATUS;
	assign hit_tlc = paddr == devctl_pkg::ADDR_TL_CONTROL;
	assign hit_mask = paddr == devctl_pkg::ADDR_IRQ_MASK;
	assign hit_any = hit_ctl | hit_sts | hit_tlc | hit_mask;
	assign setup = psel & ~penable;
	// pready is set in setup, so every access phase lasts one cycle
	assign wr_en = psel & penable & pready & pwrite & hit_any;

	// control word view; hardwired fields stay zero
	always_comb begin
		ctl_word = '0;
		ctl_word[devctl_pkg::CTL_REPORT_LSB +: 4] = report_en_r;
		ctl_word[devctl_pkg::CTL_RELAXED_ORDER] = 1'b0;
		ctl_word[devctl_pkg::CTL_PAYLOAD_LSB +: 3] = payload_r;
		ctl_word[devctl_pkg::CTL_WIDE_TAG] = wide_tag_r;
		ctl_word[devctl_pkg::CTL_PHANTOM] = 1'b0;
		ctl_word[devctl_pkg::CTL_AUX_POWER] = aux_en_r;
		ctl_word[devctl_pkg::CTL_NO_SNOOP] = 1'b0;
		ctl_word[devctl_pkg::CTL_READ_SIZE_LSB +: 3] = 3'h0;
	end

	// status word view; upper bits reserved
	always_comb begin
		sts_word = '0;
		sts_word[devctl_pkg::STS_ERR_LSB +: 4] = err_seen_r;
		sts_word[devctl_pkg::STS_AUX_PRESENT] = aux_present_r;
		sts_word[devctl_pkg::STS_OUTSTANDING] = 1'b0;
	end

	// read mux, sampled in the setup phase
	always_comb begin
		rd_nxt = '0;
		if (hit_ctl) begin
			rd_nxt[devctl_pkg::REG_W-1:0] = ctl_word;
		end else if (hit_sts) begin
			rd_nxt[devctl_pkg::REG_W-1:0] = sts_word;
		end else if (hit_tlc) begin
			rd_nxt[devctl_pkg::TLC_SEQ_TAG] = seq_tag_r;
		end else if (hit_mask) begin
			rd_nxt[devctl_pkg::NUM_ERR-1:0] = irq_mask_r;
		end
	end

	// apb answer: one wait-free access phase, error on unmapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit_any;
			// data only for reads so write cycles leave no stale echo
			prdata <= (setup & ~pwrite) ? rd_nxt : '0;
		end
	end

	// port-reset control fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			report_en_r <= devctl_pkg::CTL_RESET[3:0];
			payload_r <= devctl_pkg::PAYLOAD_128;
			wide_tag_r <= 1'b0;
		end else if (wr_en && hit_ctl) begin
			report_en_r <= pwdata[devctl_pkg::CTL_REPORT_LSB +: 4];
			payload_r <= pwdata[devctl_pkg::CTL_PAYLOAD_LSB +: 3];
			wide_tag_r <= pwdata[devctl_pkg::CTL_WIDE_TAG];
		end
	end

	// aux power enable lives in the aux well: port resets skip it
	always_ff @(posedge pclk or negedge aux_rstn) begin
		if (!aux_rstn) begin
			aux_en_r <= 1'b0;
		end else if (wr_en && hit_ctl) begin
			aux_en_r <= pwdata[devctl_pkg::CTL_AUX_POWER];
		end
	end

	// debug control and interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_tag_r <= 1'b0;
			irq_mask_r <= '0;
		end else begin
			if (wr_en && hit_tlc) begin
				seq_tag_r <= pwdata[devctl_pkg::TLC_SEQ_TAG];
			end
			if (wr_en && hit_mask) begin
				irq_mask_r <= pwdata[devctl_pkg::NUM_ERR-1:0];
			end
		end
	end

	// error inputs; unsupported request also comes from the classifier
	assign err_in = {err_evt.unsupported | unsup_req_rcvd,
		err_evt.fatal, err_evt.nonfatal, err_evt.correctable};
	assign w1c = (wr_en && hit_sts) ?
		pwdata[devctl_pkg::STS_ERR_LSB +: devctl_pkg::NUM_ERR] : '0;

	// sticky flags: set regardless of enables, set beats clear
	generate
		for (genvar i = 0; i < devctl_pkg::NUM_ERR; i++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					err_seen_r[i] <= devctl_pkg::STS_RESET[i];
				end else if (err_in[i]) begin
					err_seen_r[i] <= 1'b1;
				end else if (w1c[i]) begin
					err_seen_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// aux power detect level, registered for the status view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_present_r <= 1'b0;
		end else begin
			aux_present_r <= aux_power_detect;
		end
	end

	// debug tag generator; idle at zero outside debug mode
	assign tag_max = wide_tag_r ? devctl_pkg::TAG_MAX_WIDE :
		devctl_pkg::TAG_MAX_NARROW;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_r <= devctl_pkg::TAG_RESET;
		end else if (!seq_tag_r) begin
			tag_r <= devctl_pkg::TAG_RESET;
		end else if (tag_advance) begin
			// >= also pulls back a tag left high by narrowing
			tag_r <= (tag_r >= tag_max) ? devctl_pkg::TAG_RESET :
				tag_r + 8'h01;
		end
	end

	// registered outputs; one cycle behind the register state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			gen_tag <= devctl_pkg::TAG_RESET;
			irq <= 1'b0;
		end else begin
			ctl.unsupported_req_report_en <= report_en_r[3];
			ctl.fatal_report_en <= report_en_r[2];
			ctl.nonfatal_report_en <= report_en_r[1];
			ctl.correctable_report_en <= report_en_r[0];
			ctl.payload_256 <= payload_r == devctl_pkg::PAYLOAD_256;
			ctl.wide_tag_en <= wide_tag_r;
			ctl.aux_power_en <= aux_en_r;
			ctl.sequential_tag_debug <= seq_tag_r;
			gen_tag <= tag_r;
			irq <= |(err_seen_r & irq_mask_r);
		end
	end

	// checks
	AST_HARDWIRED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_word[devctl_pkg::CTL_RELAXED_ORDER] == 1'b0) &&
		(ctl_word[15:9] & 7'h7d) == 7'h00)
		else $error("hardwired control bit is set");
	AST_PHANTOM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && hit_ctl |->
		prdata[devctl_pkg::CTL_PHANTOM] == 1'b0)
		else $error("phantom function bit read as one");
	AST_CTL_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && hit_ctl |->
		prdata[15:11] == 5'h00)
		else $error("no-snoop or read size field read nonzero");
	AST_READ_SIZE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ctl |=> ctl_word[14:12] == 3'h0)
		else $error("read request size field took a write");
	AST_REPORT_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ctl |=> ##1 {ctl.unsupported_req_report_en,
		ctl.fatal_report_en, ctl.nonfatal_report_en,
		ctl.correctable_report_en} == $past(pwdata[3:0], 2))
		else $error("report enables did not follow the write");
	AST_PAYLOAD_MAP: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ctl.payload_256 == ($past(payload_r) == 3'h1))
		else $error("payload limit decode wrong");
	AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
		err_in[0] || err_in[1] || err_in[2] || err_in[3] |=>
		(err_seen_r & $past(err_in)) == $past(err_in))
		else $error("error event did not set its flag");
	AST_UR_SET: assert property (@(posedge pclk) disable iff (!presetn)
		unsup_req_rcvd |=> err_seen_r[3])
		else $error("unsupported request not logged");
	AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		err_seen_r[0] && !(w1c[0]) |=> err_seen_r[0])
		else $error("flag lost without a write of one");
	AST_AUX_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
		aux_power_detect |=> sts_word[4] ##0 sts_word[5] == 1'b0)
		else $error("aux power status wrong");
	AST_PENDING_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		sts_word[15:5] == 11'h000)
		else $error("pending or reserved status bit set");
	AST_AUX_KEEP: assert property (@(posedge pclk) disable iff (!aux_rstn)
		!(wr_en && hit_ctl) |=> $stable(aux_en_r))
		else $error("aux power enable changed without a write");
	AST_TAG_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		seq_tag_r && !wide_tag_r && tag_advance && tag_r == 8'h1f |=>
		tag_r == 8'h00)
		else $error("narrow tag range did not wrap at 31");
	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		|(err_seen_r & irq_mask_r) |=> irq)
		else $error("unmasked flag gave no interrupt");

	COV_FLAG_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
		err_seen_r[2] ##1 w1c[2] ##1 !err_seen_r[2]);
	COV_SET_BEATS_CLEAR: cover property (@(posedge pclk)
		disable iff (!presetn) err_in[0] && w1c[0]);
	COV_WIDE_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
		seq_tag_r && tag_advance && tag_r == 8'hff);
	COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr && penable);

endmodule : express_device_ctl_status

`default_nettype wire

/* express_device_ctl_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module express_device_ctl_status_tb;
	// byte addresses of the registers under test
	localparam logic [11:0] CA = devctl_pkg::ADDR_DEVICE_CONTROL;
	localparam logic [11:0] SA = devctl_pkg::ADDR_DEVICE_STATUS;
	localparam logic [11:0] TA = devctl_pkg::ADDR_TL_CONTROL;
	localparam logic [11:0] MA = devctl_pkg::ADDR_IRQ_MASK;
	// clock, resets, apb master
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic aux_rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// port core side
	devctl_pkg::err_evt_t err_evt = '0;
	logic unsup_req_rcvd = 1'b0;
	logic aux_power_detect = 1'b0;
	logic tag_advance = 1'b0;
	devctl_pkg::ctl_out_t ctl;
	logic [7:0] gen_tag;
	logic irq;
	// bookkeeping
	int n_errors = 0;
	int num_checks = 0;
	logic [31:0] rd;
	logic err;

	express_device_ctl_status DUT (
		.pclk(pclk), .presetn(presetn), .aux_rstn(aux_rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .err_evt(err_evt),
		.unsup_req_rcvd(unsup_req_rcvd),
		.aux_power_detect(aux_power_detect), .tag_advance(tag_advance),
		.ctl(ctl), .gen_tag(gen_tag), .irq(irq)
	);

	// 20 mhz clock
	always #25 pclk = ~pclk;

	// verdict and end of run
	task automatic results();
		$display("checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// one comparison, four-state exact
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// one apb transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic wr, input logic [11:0] addr,
		input logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		// look mid-cycle so the answer is read settled, not in a race
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a stuck slave counts as a mismatch
		if (n >= 50) n_errors++;
		rd = prdata;
		err = pslverr;
		// the rising edge with pready high completes the transfer
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// read and compare
	task automatic rchk(input string what, input logic [11:0] addr,
		input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(what, rd, exp);
	endtask : rchk

	// one-cycle event pulses from the port core
	task automatic pulse(input logic [3:0] e, input logic ur);
		@(posedge pclk);
		err_evt <= devctl_pkg::err_evt_t'(e);
		unsup_req_rcvd <= ur;
		@(posedge pclk);
		err_evt <= '0;
		unsup_req_rcvd <= 1'b0;
	endtask : pulse

	// n back-to-back tag steps, then let gen_tag catch up
	task automatic adv(input int n);
		@(posedge pclk);
		tag_advance <= 1'b1;
		repeat (n) @(posedge pclk);
		tag_advance <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : adv

	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		aux_rstn <= 1'b1;
		rchk("control reset", CA, 32'h0);
		chk("mapped slverr", {31'h0, err}, 32'h0);
		rchk("status reset", SA, 32'h0);
		// only the writable control bits take a write of all ones
		apb(1'b1, CA, 32'hffff_ffff);
		rchk("control ones", CA, 32'h05ef);
		chk("report enables", {28'h0, ctl[7:4]}, 32'hf);
		// every payload code; only code one means 256 bytes
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, CA, {24'h0, c[2:0], 5'h0});
			rchk("payload readback", CA, {24'h0, c[2:0], 5'h0});
			chk("payload 256", {31'h0, ctl.payload_256}, {31'h0, c == 1});
		end
		// flags log with all report enables off
		pulse(4'h7, 1'b0);
		rchk("flags set", SA, 32'h7);
		pulse(4'h0, 1'b1);
		rchk("unsupported rcvd", SA, 32'hf);
		apb(1'b1, SA, 32'h0);
		rchk("zero write keeps", SA, 32'hf);
		apb(1'b1, SA, 32'hffff_0005);
		rchk("one clears", SA, 32'ha);
		apb(1'b1, SA, 32'hffff);
		pulse(4'h8, 1'b0);
		rchk("unsupported evt", SA, 32'h8);
		apb(1'b1, SA, 32'h8);
		aux_power_detect <= 1'b1;
		rchk("aux detected", SA, 32'h10);
		aux_power_detect <= 1'b0;
		rchk("aux gone", SA, 32'h0);
		// interrupt: masked and unmasked events, then clear
		apb(1'b1, MA, 32'h4);
		pulse(4'h1, 1'b0);
		repeat (2) @(posedge pclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		pulse(4'h4, 1'b0);
		repeat (2) @(posedge pclk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		apb(1'b1, SA, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rchk("other flag kept", SA, 32'h1);
		// aux power enable survives a port reset, not an aux reset
		apb(1'b1, CA, 32'h0400);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk("aux en kept", CA, 32'h0400);
		chk("aux en out", {31'h0, ctl.aux_power_en}, 32'h1);
		rchk("flag cleared by reset", SA, 32'h0);
		aux_rstn <= 1'b0;
		repeat (2) @(posedge pclk);
		aux_rstn <= 1'b1;
		rchk("aux en cleared", CA, 32'h0);
		// unmapped place is refused
		apb(1'b1, 12'h200, 32'hffff);
		chk("unmapped write", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h200, 32'h0);
		chk("unmapped read", rd, 32'h0);
		// debug tags: narrow range wraps after 31, wide after 255
		apb(1'b1, TA, 32'h1);
		adv(31);
		chk("narrow top", {24'h0, gen_tag}, 32'h1f);
		chk("seq tag out", {31'h0, ctl.sequential_tag_debug}, 32'h1);
		adv(1);
		chk("narrow wrap", {24'h0, gen_tag}, 32'h0);
		apb(1'b1, CA, 32'h0100);
		adv(40);
		chk("wide step", {24'h0, gen_tag}, 32'h28);
		chk("wide tag out", {31'h0, ctl.wide_tag_en}, 32'h1);
		adv(256);
		chk("wide wrap", {24'h0, gen_tag}, 32'h28);
		apb(1'b1, TA, 32'h0);
		adv(5);
		chk("debug off", {24'h0, gen_tag}, 32'h0);
		results();
	end

	// watchdog, far beyond the roughly 510 cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		results();
	end

endmodule : express_device_ctl_status_tb

`default_nettype wire
